/* core/fsrc_pkg.sv */
// Constants, types and field layout for the flash security and reset control block.
// Assumes a 100 MHz system clock and a synchronous, active-high system reset.
//
// Behaviour
// - Reset loads security register from stored byte.
// - Security register: key enable, mass erase, factory, state.
// - Secured special mode allows only erase-all, read-ones.
// - New stored byte acts only after reset.
// - Backdoor unsecure only with key enable on.
// - Matching key forces state field to unsecure.
// - One failed compare blocks verify until reset.
// - Verify changes only the security and status registers.
// - Reset restores state from stored byte.
// - Verify never touches protection registers.
// - Unsecured chip may run every command.
// - Reset sequence loads protection, option, security.
// - Command complete flag low during reset sequence.
// - Processor accesses stalled until sequence ends.
// - Sequence end sets command complete flag.
// - Reset aborts a running command at once.
// - Aborted commands never resume after reset.
// - Key enable off: access error, no compare.
// - All-zero or all-one key: access error.
// - Mismatch keeps secure, later verifies error.
package fsrc_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RESET_SEQ_NS = 200;
  localparam int unsigned RESET_SEQ_CYCLES = (RESET_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RESET_SEQ_CYCLES - 1);

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_SECURITY = 8'h04;
  localparam logic [7:0] OFS_OPTION = 8'h08;
  localparam logic [7:0] OFS_PROT = 8'h0C;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_KEY_LO = 8'h14;
  localparam logic [7:0] OFS_KEY_HI = 8'h18;

  // ----------------------------------------
  // Status bit positions
  // ----------------------------------------
  localparam int unsigned STAT_COMMAND_COMPLETE_FLAG = 7;
  localparam int unsigned STAT_ACCESS_ERROR_FLAG = 5;
  localparam int unsigned STAT_LOCK = 1;
  localparam int unsigned STAT_MGSTAT = 0;

  // ----------------------------------------
  // Security register fields and encodings
  // ----------------------------------------
  localparam int unsigned BACKDOOR_KEY_ENABLE_LSB = 6;
  localparam int unsigned MASS_ERASE_ENABLE_LSB = 4;
  localparam int unsigned FACC_LSB = 2;
  localparam int unsigned SECST_LSB = 0;
  localparam logic [1:0] BACKDOOR_KEY_ENABLE_ON = 2'h2;
  localparam logic [1:0] SEC_UNSECURE = 2'h2;

  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_READ_ONES_ALL = 8'h40;
  localparam logic [7:0] CMD_ERASE_ALL = 8'h44;
  localparam logic [7:0] CMD_VERIFY_KEY = 8'h45;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_INIT = 2'h0,
    ST_LOAD = 2'h1,
    ST_IDLE = 2'h3,
    ST_BUSY = 2'h2
  } fsrc_state_e;

  // Contents of the nonvolatile configuration field.
  typedef struct packed {
    logic [7:0] sec_byte;
    logic [7:0] opt_byte;
    logic [31:0] prot;
    logic [63:0] key;
  } fsrc_nv_s;

  // Request to the external command engine.
  typedef struct packed {
    logic start;
    logic [7:0] code;
  } fsrc_eng_req_s;

  // Answer of the external command engine.
  typedef struct packed {
    logic done;
    logic fail;
  } fsrc_eng_rsp_s;

  // All state of the controller.
  typedef struct packed {
    fsrc_state_e st;
    logic [CNT_W-1:0] cnt;
    logic [7:0] sec;
    logic [7:0] opt;
    logic [31:0] prot;
    logic [7:0] cmd;
    logic [63:0] key;
    logic access_error_flag;
    logic mgstat;
    logic lockout;
    logic vfy;
    logic start;
    logic [31:0] rdata;
  } fsrc_regs_s;

endpackage : fsrc_pkg

/* core/fsrc_key_check.sv */
// Backdoor key comparator with all-zero and all-one detection.
// Assumes both keys are stable while their results are read.
`timescale 1ns/10ps
module fsrc_key_check #(
  parameter int unsigned WIDTH = 64
) (
  // Keys.
  input wire logic [WIDTH-1:0] key_in,
  input wire logic [WIDTH-1:0] ref_in,
  // Results.
  output logic match_out,
  output logic all_zero_out,
  output logic all_one_out
);

  // Compare the supplied key and classify its pattern.
  assign match_out = (key_in == ref_in);
  assign all_zero_out = (key_in == '0);
  assign all_one_out = (key_in == '1);

endmodule : fsrc_key_check

/* core/fsrc_ctrl.sv */
// Flash security and reset sequence controller with an APB register port.
// Assumes the nonvolatile field and engine answers are synchronous to clk_in.
`timescale 1ns/10ps
module fsrc_ctrl
  import fsrc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_in,
  // APB slave.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  // Nonvolatile configuration field and mode.
  input wire fsrc_nv_s nv_in,
  input wire logic special_mode_in,
  // Command engine.
  output fsrc_eng_req_s eng_req_out,
  input wire fsrc_eng_rsp_s eng_rsp_in,
  output logic eng_abort_out,
  // Processor side status.
  output logic cpu_hold_out,
  output logic flash_read_en_out,
  output logic secured_out,
  output logic [7:0] security_out
);

  // ----------------------------------------
  // State and decode
  // ----------------------------------------
  fsrc_regs_s regs_reg;
  fsrc_regs_s regs_next;
  logic hold;
  logic ready;
  logic command_complete_flag;
  logic secured;
  logic backdoor_key_enable_on;
  logic key_match;
  logic key_zero;
  logic key_one;
  logic setup;
  logic access;
  logic mapped;
  logic wr;
  logic launch;
  logic allowed;
  logic [31:0] rd_mux;
  logic [7:0] status_val;

  // Sequence states hold the processor off and keep the flag low.
  assign hold = (regs_reg.st == ST_INIT) || (regs_reg.st == ST_LOAD);
  assign command_complete_flag = (regs_reg.st == ST_IDLE);
  // A stalled access waits one more cycle after the sequence so that its read data is fresh.
  assign ready = !hold && (regs_reg.cnt == CNT_LAST);

  // Only one encoding of the state field counts as unsecured.
  assign secured = (regs_reg.sec[SECST_LSB +: 2] != SEC_UNSECURE);
  assign backdoor_key_enable_on = (regs_reg.sec[BACKDOOR_KEY_ENABLE_LSB +: 2] == BACKDOOR_KEY_ENABLE_ON);

  // Bus phases and address decode.
  assign setup = psel_in && !(penable_in && ready);
  assign access = psel_in && penable_in && ready;
  assign wr = access && pwrite_in;
  always_comb begin
    case (paddr_in)
      OFS_STATUS, OFS_SECURITY, OFS_OPTION, OFS_PROT, OFS_CMD, OFS_KEY_LO, OFS_KEY_HI: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Secured special mode accepts only erase-all and read-ones-all.
  assign allowed = !secured || !special_mode_in || (regs_reg.cmd == CMD_ERASE_ALL)
                   || (regs_reg.cmd == CMD_READ_ONES_ALL);
  assign launch = wr && (paddr_in == OFS_STATUS) && pwdata_in[STAT_COMMAND_COMPLETE_FLAG] && command_complete_flag;

  // Key comparator against the stored backdoor key.
  fsrc_key_check #(
    .WIDTH(64)
  ) u_key_check (
    .key_in(regs_reg.key),
    .ref_in(nv_in.key),
    .match_out(key_match),
    .all_zero_out(key_zero),
    .all_one_out(key_one)
  );

  // ----------------------------------------
  // Read multiplexer
  // ----------------------------------------
  always_comb begin
    status_val = 8'h00;
    status_val[STAT_COMMAND_COMPLETE_FLAG] = command_complete_flag;
    status_val[STAT_ACCESS_ERROR_FLAG] = regs_reg.access_error_flag;
    status_val[STAT_LOCK] = regs_reg.lockout;
    status_val[STAT_MGSTAT] = regs_reg.mgstat;
    case (paddr_in)
      OFS_STATUS: rd_mux = {24'h00_0000, status_val};
      OFS_SECURITY: rd_mux = {24'h00_0000, regs_reg.sec};
      OFS_OPTION: rd_mux = {24'h00_0000, regs_reg.opt};
      OFS_PROT: rd_mux = regs_reg.prot;
      OFS_CMD: rd_mux = {24'h00_0000, regs_reg.cmd};
      OFS_KEY_LO: rd_mux = regs_reg.key[31:0];
      OFS_KEY_HI: rd_mux = regs_reg.key[63:32];
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    regs_next = regs_reg;
    regs_next.start = 1'b0;
    // Read data is refreshed until the access completes, so it leaves a flop.
    if (setup) begin
      regs_next.rdata = rd_mux;
    end
    // Software clears come first so that a hardware set below wins.
    if (wr && (paddr_in == OFS_STATUS) && pwdata_in[STAT_ACCESS_ERROR_FLAG]) begin
      regs_next.access_error_flag = 1'b0;
    end
    // Command and key bytes are writable only while no command runs.
    if (wr && command_complete_flag) begin
      case (paddr_in)
        OFS_CMD: regs_next.cmd = pwdata_in[7:0];
        OFS_KEY_LO: regs_next.key[31:0] = pwdata_in;
        OFS_KEY_HI: regs_next.key[63:32] = pwdata_in;
        default: regs_next.cmd = regs_reg.cmd;
      endcase
    end
    case (regs_reg.st)
      ST_INIT: begin
        // The sequence waits out its fixed length before loading.
        if (regs_reg.cnt == CNT_LAST) begin
          regs_next.st = ST_LOAD;
        end else begin
          regs_next.cnt = regs_reg.cnt + 1'b1;
        end
      end
      ST_LOAD: begin
        // Configuration comes from the stored field, never from old state.
        regs_next.sec = nv_in.sec_byte;
        regs_next.opt = nv_in.opt_byte;
        regs_next.prot = nv_in.prot;
        regs_next.cnt = '0;
        regs_next.st = ST_IDLE;
      end
      ST_IDLE: begin
        // The first idle cycle still stalls the bus; later ones do not.
        regs_next.cnt = CNT_LAST;
        if (launch) begin
          regs_next.mgstat = 1'b0;
          if (!allowed) begin
            regs_next.access_error_flag = 1'b1;
          end else if (regs_reg.cmd == CMD_VERIFY_KEY) begin
            regs_next.vfy = 1'b1;
            regs_next.st = ST_BUSY;
          end else begin
            regs_next.start = 1'b1;
            regs_next.st = ST_BUSY;
          end
        end
      end
      ST_BUSY: begin
        if (regs_reg.vfy) begin
          // Verification touches only the security and status state.
          regs_next.vfy = 1'b0;
          regs_next.st = ST_IDLE;
          if (!backdoor_key_enable_on) begin
            regs_next.access_error_flag = 1'b1;
          end else if (regs_reg.lockout) begin
            regs_next.access_error_flag = 1'b1;
          end else if (key_zero || key_one) begin
            regs_next.access_error_flag = 1'b1;
          end else if (!key_match) begin
            regs_next.access_error_flag = 1'b1;
            regs_next.lockout = 1'b1;
          end else begin
            regs_next.sec[SECST_LSB +: 2] = SEC_UNSECURE;
          end
        end else if (eng_rsp_in.done) begin
          regs_next.mgstat = eng_rsp_in.fail;
          regs_next.st = ST_IDLE;
          // A verified erase-all releases security.
          if ((regs_reg.cmd == CMD_ERASE_ALL) && !eng_rsp_in.fail) begin
            regs_next.sec[SECST_LSB +: 2] = SEC_UNSECURE;
          end
        end
      end
      default: begin
        regs_next.st = ST_INIT;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Reset drops any command in flight and restarts the sequence.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      regs_reg <= '0;
    end else begin
      regs_reg <= regs_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // The engine is told to stop whenever reset is present.
  assign eng_abort_out = reset_in;
  assign eng_req_out.start = regs_reg.start;
  assign eng_req_out.code = regs_reg.cmd;
  assign pready_out = ready;
  assign prdata_out = regs_reg.rdata;
  assign pslverr_out = access && !mapped;
  assign cpu_hold_out = hold;
  assign flash_read_en_out = !hold;
  assign secured_out = secured;
  assign security_out = regs_reg.sec;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_command_complete_flag_low_seq: assert property (@(posedge clk_in) disable iff (reset_in)
    hold |-> !command_complete_flag)
    else $error("command complete flag set during reset sequence");

  a_bus_stall_hold: assert property (@(posedge clk_in) disable iff (reset_in)
    (regs_reg.st == ST_INIT) |-> !pready_out && !flash_read_en_out)
    else $error("processor access not stalled during sequence");

  a_seq_end_flag: assert property (@(posedge clk_in) disable iff (reset_in)
    (regs_reg.st == ST_LOAD) |=> command_complete_flag && !cpu_hold_out)
    else $error("sequence end did not set command complete flag");

  a_sec_load_nv: assert property (@(posedge clk_in) disable iff (reset_in)
    (regs_reg.st == ST_LOAD) |=> (security_out == $past(nv_in.sec_byte)))
    else $error("security register not loaded from stored byte");

  a_lockout_sticky: assert property (@(posedge clk_in) disable iff (reset_in)
    regs_reg.lockout |=> regs_reg.lockout)
    else $error("lockout cleared without reset");

  a_backdoor_key_enable_off_err: assert property (@(posedge clk_in) disable iff (reset_in)
    regs_reg.vfy && !backdoor_key_enable_on |=> regs_reg.access_error_flag && $stable(security_out) && !regs_reg.lockout)
    else $error("disabled key verify did not fail cleanly");

  a_key_match_unsec: assert property (@(posedge clk_in) disable iff (reset_in)
    regs_reg.vfy && backdoor_key_enable_on && !regs_reg.lockout && key_match && !key_zero && !key_one
    |=> !secured_out && command_complete_flag)
    else $error("matching key did not unsecure");

  a_lockout_refuse: assert property (@(posedge clk_in) disable iff (reset_in)
    regs_reg.vfy && regs_reg.lockout |=> regs_reg.access_error_flag && (secured_out == $past(secured_out)))
    else $error("verify ran while locked out");

  a_prot_stable: assert property (@(posedge clk_in) disable iff (reset_in)
    (regs_reg.st != ST_LOAD) |=> $stable(regs_reg.prot) && $stable(regs_reg.opt))
    else $error("protection changed outside reset sequence");

  a_gate_secure: assert property (@(posedge clk_in) disable iff (reset_in)
    eng_req_out.start && special_mode_in && $past(secured)
    |-> (eng_req_out.code == CMD_ERASE_ALL) || (eng_req_out.code == CMD_READ_ONES_ALL))
    else $error("forbidden command started while secured");

  a_no_resume: assert property (@(posedge clk_in) disable iff (reset_in)
    hold |-> !eng_req_out.start ##1 (hold || !eng_req_out.start))
    else $error("command started during reset sequence");

  a_abort_reset: assert property (@(posedge clk_in)
    reset_in |=> !eng_req_out.start && cpu_hold_out)
    else $error("command not dropped by reset");

  a_stall_release: assert property (@(posedge clk_in) disable iff (reset_in)
    (regs_reg.st == ST_LOAD) |=> !pready_out ##1 pready_out)
    else $error("bus stall not released after sequence");

  a_opt_load_nv: assert property (@(posedge clk_in) disable iff (reset_in)
    (regs_reg.st == ST_LOAD)
    |=> (regs_reg.opt == $past(nv_in.opt_byte)) && (regs_reg.prot == $past(nv_in.prot)))
    else $error("option or protection not loaded from stored field");

  a_key_pattern_err: assert property (@(posedge clk_in) disable iff (reset_in)
    regs_reg.vfy && backdoor_key_enable_on && !regs_reg.lockout && (key_zero || key_one)
    |=> regs_reg.access_error_flag && !regs_reg.lockout && (secured_out == $past(secured_out)))
    else $error("blank key pattern not refused");

  a_key_miss_lock: assert property (@(posedge clk_in) disable iff (reset_in)
    regs_reg.vfy && backdoor_key_enable_on && !key_zero && !key_one && !key_match
    |=> regs_reg.access_error_flag && regs_reg.lockout && (secured_out == $past(secured_out)))
    else $error("key mismatch did not lock out");

endmodule : fsrc_ctrl

/* testbench/fsrc_eng_model.sv */
// Behavioural command engine that answers each start pulse after a set delay.
// Assumes start is a one-cycle pulse and the abort line resets the engine.
`timescale 1ns/10ps
module fsrc_eng_model
  import fsrc_pkg::*;
(
  // Clock and abort.
  input wire logic clk_in,
  input wire logic reset_in,
  // Request, answer timing and outcome.
  input wire fsrc_eng_req_s req_in,
  input wire logic [3:0] delay_in,
  input wire logic fail_in,
  output fsrc_eng_rsp_s rsp_out
);
  logic [4:0] cnt_reg;

  // Count the busy time; done pulses once, and fail shows only with done.
  always_ff @(posedge clk_in) begin
    rsp_out <= '0;
    if (reset_in) begin
      cnt_reg <= 5'h0;
    end else if (req_in.start) begin
      cnt_reg <= {1'b0, delay_in} + 5'h1;
    end else if (cnt_reg != 5'h0) begin
      cnt_reg <= cnt_reg - 5'h1;
      if (cnt_reg == 5'h1) begin
        rsp_out <= '{done: 1'b1, fail: fail_in};
      end
    end
  end
endmodule : fsrc_eng_model

/* testbench/tb_flash_security_reset_control.sv */
// Self-checking bench for the flash security and reset controller.
// Assumes the package, the controller and the engine model are compiled first.
`timescale 1ns/10ps
module tb_flash_security_reset_control import fsrc_pkg::*;;
  logic clk_in, reset_in, psel, penable, pwrite, pready, pslverr, special, fail, abort, hold, rd_en, secured;
  logic [7:0] paddr, security;
  logic [31:0] pwdata, prdata, rnd, mon_m, mon_e;
  logic slverr;
  logic [3:0] delay;
  fsrc_nv_s nv;
  fsrc_eng_req_s req;
  fsrc_eng_rsp_s rsp;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int failures = 0;
  int checks = 0;
  int cycles = 0;

  fsrc_ctrl i_dut (.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata),
    .pslverr_out(pslverr), .nv_in(nv), .special_mode_in(special), .eng_req_out(req), .eng_rsp_in(rsp),
    .eng_abort_out(abort), .cpu_hold_out(hold), .flash_read_en_out(rd_en), .secured_out(secured),
    .security_out(security));
  fsrc_eng_model i_eng (.clk_in(clk_in), .reset_in(abort), .req_in(req), .delay_in(delay),
    .fail_in(fail), .rsp_out(rsp));

  // 100 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Compare one value and count it.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // Print the counts and the verdict, then stop.
  task automatic end_of_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // Next value of the pseudo-random sequence.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction : lfsr

  // One APB transfer; the request is held until pready is seen high, then one idle edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask : apb

  // Read with a noted expectation under a mask.
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  // Load the key registers.
  task automatic key(input logic [63:0] k);
    apb(1'b1, OFS_KEY_LO, k[31:0]);
    apb(1'b1, OFS_KEY_HI, k[63:32]);
  endtask : key

  // Launch a command and leave time for it to finish.
  task automatic run(input logic [7:0] c);
    apb(1'b1, OFS_CMD, {24'h00_0000, c});
    apb(1'b1, OFS_STATUS, 32'h0000_0080);
    repeat (10) @(posedge clk_in);
  endtask : run

  // Reset with a given stored security byte and mode, then check the start-up sequence.
  task automatic do_reset(input logic [7:0] sec, input logic sp);
    nv.sec_byte <= sec;
    special <= sp;
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    chk(hold, 1'b1);
    chk(req.start, 1'b0);
    rd(OFS_STATUS, 32'h0000_0080, 32'h0000_00A3);
    chk(rd_en, 1'b1);
    rd(OFS_SECURITY, {24'h00_0000, sec}, 32'hFFFF_FFFF);
  endtask : do_reset

  // Answer monitor: each completed read is compared with the oldest note.
  always @(posedge clk_in) begin
    if (psel && penable && pready === 1'b1) begin
      slverr = pslverr;
      if (!pwrite && exp_q.size() > 0) begin
        mon_m = msk_q.pop_front();
        mon_e = exp_q.pop_front();
        chk(prdata & mon_m, mon_e);
      end
    end
  end

  // Cut a hang short.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_of_test;
    end
  end

  // Main sequence.
  initial begin
    reset_in = 1'b1;
    {psel, penable, pwrite, special, fail} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    delay = 4'h0;
    nv = '0;
    rnd = lfsr(32'h0000_971e);
    @(posedge clk_in);
    nv.opt_byte <= rnd[7:0];
    nv.prot <= rnd;
    rnd = lfsr(rnd);
    nv.key <= {1'b0, rnd, rnd[30:1], 1'b1};
    delay <= {2'b00, rnd[1:0]};
    do_reset(8'h80, 1'b1);
    rd(OFS_OPTION, {24'h00_0000, nv.opt_byte}, 32'hFFFF_FFFF);
    rd(OFS_PROT, nv.prot, 32'hFFFF_FFFF);
    chk(slverr, 1'b0);
    rd(8'h3C, 32'h0000_0000, 32'hFFFF_FFFF);
    chk(slverr, 1'b1);
    chk(secured, 1'b1);
    nv.sec_byte <= 8'h82;
    repeat (3) @(posedge clk_in);
    chk(security, 8'h80);
    nv.sec_byte <= 8'h80;
    run(8'h07);
    rd(OFS_STATUS, 32'h0000_00A0, 32'h0000_00A3);
    apb(1'b1, OFS_STATUS, 32'h0000_0020);
    fail <= 1'b1;
    run(CMD_READ_ONES_ALL);
    rd(OFS_STATUS, 32'h0000_0081, 32'h0000_00A3);
    fail <= 1'b0;
    special <= 1'b0;
    key(64'h0);
    run(CMD_VERIFY_KEY);
    rd(OFS_STATUS, 32'h0000_00A0, 32'h0000_00A2);
    apb(1'b1, OFS_STATUS, 32'h0000_0020);
    key(64'hFFFF_FFFF_FFFF_FFFF);
    run(CMD_VERIFY_KEY);
    rd(OFS_STATUS, 32'h0000_00A0, 32'h0000_00A2);
    apb(1'b1, OFS_STATUS, 32'h0000_0020);
    key(nv.key);
    run(CMD_VERIFY_KEY);
    rd(OFS_STATUS, 32'h0000_0080, 32'h0000_00A2);
    chk(security, 8'h82);
    chk(secured, 1'b0);
    rd(OFS_PROT, nv.prot, 32'hFFFF_FFFF);
    special <= 1'b1;
    run(8'h07);
    rd(OFS_STATUS, 32'h0000_0080, 32'h0000_00A2);
    do_reset(8'h80, 1'b0);
    chk(secured, 1'b1);
    key(nv.key ^ 64'h100);
    run(CMD_VERIFY_KEY);
    rd(OFS_STATUS, 32'h0000_00A2, 32'h0000_00A2);
    apb(1'b1, OFS_STATUS, 32'h0000_0020);
    key(nv.key);
    run(CMD_VERIFY_KEY);
    rd(OFS_STATUS, 32'h0000_00A2, 32'h0000_00A2);
    chk(secured, 1'b1);
    do_reset(8'h00, 1'b0);
    key(nv.key);
    run(CMD_VERIFY_KEY);
    rd(OFS_STATUS, 32'h0000_00A0, 32'h0000_00A2);
    apb(1'b1, OFS_STATUS, 32'h0000_0020);
    run(8'h07);
    rd(OFS_STATUS, 32'h0000_0080, 32'h0000_00A2);
    delay <= 4'hF;
    apb(1'b1, OFS_STATUS, 32'h0000_0080);
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b1;
    @(posedge clk_in);
    chk(abort, 1'b1);
    delay <= {2'b00, rnd[1:0]};
    do_reset(8'h80, 1'b1);
    run(CMD_ERASE_ALL);
    chk(security[1:0], 2'b10);
    end_of_test;
  end
endmodule : tb_flash_security_reset_control
